//--- dv/pmbus_host_model.sv
// Host model that issues word reads and writes on the command port.
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  input wire logic clk_i,
  input wire logic rsp_valid_i,
  input wire logic [15:0] rsp_rdata_i,
  input wire logic rsp_invalid_i,
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic [7:0] cmd_phase_o,
  output logic [15:0] cmd_wdata_o
);
  // Lines start quiet so the device sees no request at time zero.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_phase_o = 8'h00;
    cmd_wdata_o = 16'h0000;
  end
  // One word transfer; released lines show inverted values so stale data never matches.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] ph,
      input logic [15:0] wd, output logic [15:0] rd, output logic inv, output logic ok);
    ok = 1'b0;
    rd = 16'h0000;
    inv = 1'b0;
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_code_o = code;
    cmd_phase_o = ph;
    cmd_wdata_o = wd;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_write_o = ~wr;
    cmd_code_o = ~code;
    cmd_phase_o = ~ph;
    cmd_wdata_o = ~wd;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (rsp_valid_i === 1'b1) begin
        ok = 1'b1;
        rd = rsp_rdata_i;
        inv = rsp_invalid_i;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask : xfer
endmodule : pmbus_host_model
`default_nettype wire

//--- dv/tb.sv
// Testbench for the offset trim and overvoltage limit commands.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import trim_limit_pkg::*;
  logic clk_i, resetn_i, cmd_valid_i, cmd_write_i, rsp_valid_o, rsp_invalid_o;
  logic [7:0] cmd_code_i, cmd_phase_i, ov_response_i;
  logic [15:0] cmd_wdata_i, rsp_rdata_o, nvm_ov_word_i, vout_command_i, vout_sense_i, rdv;
  logic [2:0] stack_phases_i;
  logic nvm_restore_i, vout_mode_rel_i, conv_enable_i, ov_fault_o, ov_event_o;
  logic shutdown_o, restart_o, seen;
  logic [63:0] nvm_offset_words_i, phase_offsets_o;
  logic [4:0] vout_exp_i;
  logic [23:0] ton_rise_cycles_i;
  logic [17:0] offset_sum_o;
  logic [10:0] ov_pct_o;
  int num_errors, checks;
  iout_offset_ov_limit iout_offset_ov_limit_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
    .cmd_phase_i(cmd_phase_i), .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .rsp_invalid_o(rsp_invalid_o), .stack_phases_i(stack_phases_i),
    .nvm_restore_i(nvm_restore_i), .nvm_offset_words_i(nvm_offset_words_i),
    .nvm_ov_word_i(nvm_ov_word_i), .vout_mode_rel_i(vout_mode_rel_i), .vout_exp_i(vout_exp_i),
    .vout_command_i(vout_command_i), .vout_sense_i(vout_sense_i),
    .conv_enable_i(conv_enable_i), .ov_response_i(ov_response_i),
    .ton_rise_cycles_i(ton_rise_cycles_i), .phase_offsets_o(phase_offsets_o),
    .offset_sum_o(offset_sum_o), .ov_pct_o(ov_pct_o), .ov_fault_o(ov_fault_o),
    .ov_event_o(ov_event_o), .shutdown_o(shutdown_o), .restart_o(restart_o));
  pmbus_host_model pmbus_host_model_i (.clk_i(clk_i), .rsp_valid_i(rsp_valid_o),
    .rsp_rdata_i(rsp_rdata_o), .rsp_invalid_i(rsp_invalid_o), .cmd_valid_o(cmd_valid_i),
    .cmd_write_o(cmd_write_i), .cmd_code_o(cmd_code_i), .cmd_phase_o(cmd_phase_i),
    .cmd_wdata_o(cmd_wdata_i));
  // Free-running clock at the core rate.
  always #2.5 clk_i = ~clk_i;
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Compares one value and counts the result.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : check
  // One command; the answer's invalid flag is compared and read data kept in rdv.
  task automatic xf(input logic wr, input logic [7:0] code, input logic [7:0] ph,
      input logic [15:0] wd, input logic inv_exp);
    logic inv;
    logic ok;
    pmbus_host_model_i.xfer(wr, code, ph, wd, rdv, inv, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      test_done();
    end
    check(inv, inv_exp);
  endtask : xf
  // Lets registered outputs land.
  task automatic settle();
    repeat (3) @(negedge clk_i);
  endtask : settle
  // Converts a five-eleven word to amperes in 2^-10 steps.
  function automatic logic [31:0] lin2q(input logic [15:0] w);
    logic signed [31:0] m;
    int e;
    m = {{21{w[10]}}, w[10:0]};
    e = $signed(w[15:11]) + Q_FRAC;
    lin2q = (e >= 0) ? m <<< e : m >>> -e;
  endfunction : lin2q
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    num_errors = 0;
    checks = 0;
    clk_i = 1'b0;
    resetn_i = 1'b0;
    stack_phases_i = 3'h4;
    nvm_restore_i = 1'b0;
    nvm_offset_words_i = 64'h0;
    nvm_ov_word_i = 16'hffff;
    vout_mode_rel_i = 1'b1;
    vout_exp_i = 5'h17;
    vout_command_i = 16'd1000;
    vout_sense_i = 16'd1500;
    conv_enable_i = 1'b0;
    ov_response_i = 8'h00;
    ton_rise_cycles_i = 24'h4;
    repeat (6) @(negedge clk_i);
    check(ov_pct_o, 11'd1400);
    resetn_i = 1'b1;
    settle();
    check(ov_fault_o, 1'b1);
    check(shutdown_o, 1'b0);
    vout_sense_i = 16'd1000;
    xf(1'b0, CMD_OFFSET_TRIM, 8'h00, 16'h0, 1'b0);
    check(rdv, 16'he000);
    xf(1'b0, CMD_OV_THRESHOLD, 8'h00, 16'h0, 1'b0);
    check(rdv, 16'hffff);
    $display("reset test done");
    xf(1'b1, CMD_OFFSET_TRIM, 8'h01, 16'he005, 1'b0);
    xf(1'b1, CMD_OFFSET_TRIM, 8'h02, 16'hb003, 1'b0);
    xf(1'b1, CMD_OFFSET_TRIM, 8'h03, 16'he780, 1'b0);
    settle();
    check(phase_offsets_o[15:0], 16'h0000);
    check(phase_offsets_o[31:16], 16'h0140);
    check(phase_offsets_o[47:32], 16'h0003);
    check(phase_offsets_o[63:48], 16'he000);
    check(offset_sum_o, 18'h3e143);
    xf(1'b1, CMD_OFFSET_TRIM, 8'h03, 16'he080, 1'b1);
    xf(1'b1, CMD_OFFSET_TRIM, 8'h03, 16'he07f, 1'b0);
    xf(1'b1, CMD_OFFSET_TRIM, 8'h04, 16'he005, 1'b1);
    xf(1'b1, 8'h41, 8'h00, 16'h0, 1'b1);
    xf(1'b0, CMD_OFFSET_TRIM, 8'h01, 16'h0, 1'b0);
    check(rdv, 16'he005);
    settle();
    check(phase_offsets_o[63:48], 16'h1fc0);
    xf(1'b1, CMD_OFFSET_TRIM, PHASE_BCAST, 16'h0028, 1'b1);
    xf(1'b1, CMD_OFFSET_TRIM, PHASE_BCAST, 16'h0004, 1'b0);
    settle();
    for (int p = 0; p < 4; p++) check(phase_offsets_o[16*p +: 16], 16'h0400);
    check(offset_sum_o, 18'h01000);
    xf(1'b0, CMD_OFFSET_TRIM, PHASE_BCAST, 16'h0, 1'b0);
    check(lin2q(rdv), 32'd4096);
    nvm_offset_words_i = {32'h0, 16'he005, 16'hb021};
    @(negedge clk_i);
    nvm_restore_i = 1'b1;
    @(negedge clk_i);
    nvm_restore_i = 1'b0;
    settle();
    check(phase_offsets_o[31:0], 32'h01400040);
    xf(1'b0, CMD_OFFSET_TRIM, 8'h00, 16'h0, 1'b0);
    check(rdv, 16'he001);
    $display("offset test done");
    conv_enable_i = 1'b1;
    xf(1'b1, CMD_OV_THRESHOLD, 8'h00, 16'd569, 1'b0);
    settle();
    check(ov_pct_o, 11'd1125);
    xf(1'b1, CMD_OV_THRESHOLD, 8'h00, 16'd577, 1'b0);
    xf(1'b1, CMD_OV_THRESHOLD, 8'h00, 16'd530, 1'b1);
    xf(1'b1, CMD_OV_THRESHOLD, 8'h00, 16'd800, 1'b1);
    xf(1'b0, CMD_OV_THRESHOLD, 8'h00, 16'h0, 1'b0);
    check(rdv, 16'd577);
    check(ov_pct_o, 11'd1150);
    conv_enable_i = 1'b0;
    settle();
    check(ov_pct_o, 11'd1200);
    conv_enable_i = 1'b1;
    ov_response_i = 8'h40;
    vout_sense_i = 16'd1160;
    settle();
    check(ov_fault_o, 1'b1);
    vout_command_i = 16'd1100;
    settle();
    check(ov_fault_o, 1'b0);
    repeat (20) @(negedge clk_i);
    check(shutdown_o, 1'b1);
    conv_enable_i = 1'b0;
    vout_command_i = 16'd1000;
    vout_sense_i = 16'd1000;
    ov_response_i = 8'h88;
    settle();
    conv_enable_i = 1'b1;
    settle();
    vout_sense_i = 16'd1160;
    seen = 1'b0;
    for (int i = 0; i < 60 && !seen; i++) begin
      @(negedge clk_i);
      if (restart_o === 1'b1) seen = 1'b1;
    end
    check(seen, 1'b1);
    vout_sense_i = 16'd1000;
    vout_mode_rel_i = 1'b0;
    xf(1'b1, CMD_OV_THRESHOLD, 8'h00, 16'h0465, 1'b0);
    settle();
    check(ov_pct_o, 11'd1125);
    vout_command_i = 16'd1024;
    xf(1'b0, CMD_OV_THRESHOLD, 8'h00, 16'h0, 1'b0);
    check(rdv, 16'h0465);
    settle();
    check(ov_pct_o, 11'd1100);
    $display("limit test done");
    test_done();
  end
endmodule : tb
bind iout_offset_ov_limit trim_limit_asserts trim_limit_asserts_i (.clk_i(clk_i),
  .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
  .cmd_phase_i(cmd_phase_i), .vout_command_i(vout_command_i), .vout_sense_i(vout_sense_i),
  .ov_response_i(ov_response_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
  .rsp_invalid_o(rsp_invalid_o), .ov_pct_o(ov_pct_o), .ov_fault_o(ov_fault_o),
  .ov_event_o(ov_event_o), .shutdown_o(shutdown_o));
`default_nettype wire

//--- dv/trim_limit_asserts.sv
// Concurrent checks on the command port and overvoltage outputs.
`timescale 1ns/1ps
`default_nettype none
module trim_limit_asserts
  import trim_limit_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] cmd_phase_i,
  input wire logic [15:0] vout_command_i,
  input wire logic [15:0] vout_sense_i,
  input wire logic [7:0] ov_response_i,
  input wire logic rsp_valid_o,
  input wire logic [15:0] rsp_rdata_o,
  input wire logic rsp_invalid_o,
  input wire logic [10:0] ov_pct_o,
  input wire logic ov_fault_o,
  input wire logic ov_event_o,
  input wire logic shutdown_o
);
  // ---------------------------------------------------------------
  // Command answers
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  rsp_timing_a: assert property (rsp_valid_o == $past(cmd_valid_i))
    else $error("answer strobe out of step");
  rsp_idle_a: assert property (!rsp_valid_o |-> rsp_rdata_o == 16'h0000 && !rsp_invalid_o)
    else $error("answer lines busy while idle");
  bad_code_a: assert property (cmd_valid_i && cmd_code_i != CMD_OFFSET_TRIM &&
    cmd_code_i != CMD_OV_THRESHOLD |=> rsp_invalid_o)
    else $error("unknown code accepted");
  bad_phase_a: assert property (cmd_valid_i && cmd_code_i == CMD_OFFSET_TRIM &&
    cmd_phase_i > PHASE_LAST && cmd_phase_i != PHASE_BCAST |=> rsp_invalid_o)
    else $error("bad phase accepted");
  // ---------------------------------------------------------------
  // Overvoltage threshold and response
  // ---------------------------------------------------------------
  // threshold grid.
  pct_grid_a: assert property (ov_pct_o >= OV_PCT_MIN && ov_pct_o <= OV_PCT_MAX &&
    (ov_pct_o - OV_PCT_MIN) % OV_PCT_STEP == 0)
    else $error("threshold off the grid");
  low_no_fault_a: assert property ((vout_sense_i * 1000 <= vout_command_i * 1050) [*2]
    |=> !ov_fault_o)
    else $error("fault below the lowest threshold");
  high_fault_a: assert property ((vout_sense_i * 1000 > vout_command_i * 1400) [*3]
    |=> ov_fault_o)
    else $error("fault missed above the highest threshold");
  event_edge_a: assert property (ov_event_o |-> ov_fault_o && !$past(ov_fault_o))
    else $error("event without a fault rise");
  shut_follow_a: assert property (ov_event_o && ov_response_i[7:6] != RESP_IGNORE
    |=> shutdown_o)
    else $error("no shutdown after fault");
endmodule : trim_limit_asserts
`default_nettype wire

//--- src/iout_offset_ov_limit.sv
// Offset trim and overvoltage fault limit command block with fault response.
`timescale 1ns/1ps
`default_nettype none
module iout_offset_ov_limit
  import trim_limit_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] cmd_phase_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic [15:0] rsp_rdata_o,
  output logic rsp_invalid_o,
  input wire logic [2:0] stack_phases_i,
  input wire logic nvm_restore_i,
  input wire logic [63:0] nvm_offset_words_i,
  input wire logic [15:0] nvm_ov_word_i,
  input wire logic vout_mode_rel_i,
  input wire logic [4:0] vout_exp_i,
  input wire logic [15:0] vout_command_i,
  input wire logic [15:0] vout_sense_i,
  input wire logic conv_enable_i,
  input wire logic [7:0] ov_response_i,
  input wire logic [23:0] ton_rise_cycles_i,
  output logic [63:0] phase_offsets_o,
  output logic [17:0] offset_sum_o,
  output logic [10:0] ov_pct_o,
  output logic ov_fault_o,
  output logic ov_event_o,
  output logic shutdown_o,
  output logic restart_o
);
  // ---------------------------------------------------------------
  // Number format helpers
  // ---------------------------------------------------------------
  // Decodes a five/eleven float offset word to 2^-10 A fixed point.
  function automatic logic signed [47:0] decode_word(input logic [15:0] w);
    logic signed [5:0] sh;
    logic signed [47:0] m;
    sh = 6'($signed(w[EXP_MSB:EXP_LSB])) + 6'(Q_FRAC);
    m = 48'($signed(w[MAN_MSB:0]));
    if (sh >= 0) decode_word = m <<< sh;
    else decode_word = m >>> (-sh);
  endfunction : decode_word
  // Encodes fixed point with the finest exponent that fits eleven bits.
  function automatic logic [15:0] encode_word(input logic signed [17:0] v);
    logic signed [17:0] t;
    logic done;
    encode_word = 16'h0000;
    done = 1'b0;
    for (int s = 0; s <= ENC_MAX_SHIFT; s++) begin
      t = v >>> s;
      if (!done && t >= -18'sd1024 && t <= 18'sd1023) begin
        encode_word = {5'(s - Q_FRAC), t[MAN_MSB:0]};
        done = 1'b1;
      end
    end
  endfunction : encode_word
  // Maps a limit word to a hardware percentage; bit 11 is write validity.
  function automatic logic [11:0] map_limit(input logic [15:0] w, input logic [31:0] rf,
                                            input logic conv_on);
    logic [63:0] lhs;
    logic [63:0] pct;
    logic found;
    lhs = 64'(w) * 64'(PCT_SCALE);
    found = 1'b0;
    map_limit = {1'b0, OV_PCT_MAX};
    for (int i = 0; i < OV_PCT_STEPS; i++) begin
      pct = 64'(OV_PCT_MIN + OV_PCT_STEP * i);
      if (!found && (conv_on || (pct >= 64'(OV_OFF_MIN) &&
          (pct - 64'(OV_OFF_MIN)) % 64'(OV_OFF_STEP) == 64'd0)) &&
          lhs <= 64'(rf) * pct) begin
        map_limit[10:0] = pct[10:0];
        found = 1'b1;
      end
    end
    map_limit[11] = (lhs >= 64'(rf) * 64'(OV_PCT_MIN)) &&
                    (lhs <= 64'(rf) * 64'(OV_PCT_MAX));
  endfunction : map_limit

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [15:0] word_ff [MAX_PHASES];
  logic signed [15:0] q_ff [MAX_PHASES];
  logic [15:0] ov_word_ff;
  logic [2:0] n_phase_ff;
  logic por_done_ff;
  resp_state_t state_ff;
  logic [27:0] count_ff;
  logic [2:0] attempts_ff;

  // Decoded request and range checks.
  logic sel_offset;
  logic sel_ov;
  logic phase_ok;
  logic bcast;
  logic signed [47:0] wr_q;
  logic signed [47:0] per_q;
  logic wr_off_ok;
  logic [31:0] lim_ref;
  logic [11:0] wr_map;
  logic [11:0] cur_map;
  logic signed [17:0] bcast_rd;
  logic [1:0] resp_mode;
  logic [2:0] resp_retry;
  logic [2:0] resp_delay;
  logic [63:0] sense_lhs;

  assign sel_offset = cmd_code_i == CMD_OFFSET_TRIM;
  assign sel_ov = cmd_code_i == CMD_OV_THRESHOLD;
  assign bcast = cmd_phase_i == PHASE_BCAST;
  assign phase_ok = bcast || (cmd_phase_i <= PHASE_LAST &&
                              {1'b0, cmd_phase_i[1:0]} < n_phase_ff);
  assign wr_q = decode_word(cmd_wdata_i);

  always_comb begin
    case (n_phase_ff)
      3'h2: per_q = wr_q >>> 1;
      3'h3: per_q = wr_q / 48'sd3;
      3'h4: per_q = wr_q >>> 2;
      default: per_q = wr_q;
    endcase
  end

  assign wr_off_ok = bcast ? (per_q >= OFFSET_MIN_Q && per_q <= OFFSET_MAX_Q) :
                             (wr_q >= OFFSET_MIN_Q && wr_q <= OFFSET_MAX_Q);
  assign bcast_rd = 18'(q_ff[0]) * $signed({15'h0000, n_phase_ff});

  // Reference of the limit: the voltage command, or in relative mode unity, raised to 2^-exponent for a negative exponent.
  always_comb begin
    lim_ref = {16'h0000, vout_command_i};
    if (vout_mode_rel_i) begin
      lim_ref = 32'h0000_0001;
      if (vout_exp_i[4]) lim_ref = 32'h0000_0001 << (6'd32 - {1'b0, vout_exp_i});
    end
  end

  assign wr_map = map_limit(cmd_wdata_i, lim_ref, 1'b1);
  assign cur_map = map_limit(ov_word_ff, lim_ref, conv_enable_i);
  assign sense_lhs = 64'(vout_sense_i) * 64'(PCT_SCALE);
  assign resp_mode = ov_response_i[7:RESP_MODE_LSB];
  assign resp_retry = ov_response_i[RESP_MODE_LSB-1:RESP_RETRY_LSB];
  assign resp_delay = ov_response_i[RESP_RETRY_LSB-1:0];

  // ---------------------------------------------------------------
  // Stack configuration
  // ---------------------------------------------------------------
  // latch phase count
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      por_done_ff <= 1'b0;
      n_phase_ff <= PHASES_RST;
    end else if (!por_done_ff) begin
      por_done_ff <= 1'b1;
      if (stack_phases_i >= 3'h1 && stack_phases_i <= 3'(MAX_PHASES))
        n_phase_ff <= stack_phases_i;
    end
  end

  // ---------------------------------------------------------------
  // Offset trim storage
  // ---------------------------------------------------------------
  // Per-phase words, with restore and host writes.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int p = 0; p < MAX_PHASES; p++) begin
        word_ff[p] <= {OFFSET_EXP_RST, 11'h000};
        q_ff[p] <= 16'sh0000;
      end
    end else if (nvm_restore_i) begin
      for (int p = 0; p < MAX_PHASES; p++) begin
        word_ff[p] <= {OFFSET_EXP_RST,
                       11'($signed(decode_word(nvm_offset_words_i[16*p +: 16]) +
                       48'sd32) >>> NVM_GRID_SHIFT)};
        q_ff[p] <= 16'(($signed(decode_word(nvm_offset_words_i[16*p +: 16]) +
                   48'sd32) >>> NVM_GRID_SHIFT) <<< NVM_GRID_SHIFT);
      end
    end else if (cmd_valid_i && cmd_write_i && sel_offset && phase_ok && wr_off_ok) begin
      if (bcast) begin
        for (int p = 0; p < MAX_PHASES; p++) begin
          word_ff[p] <= encode_word(18'(per_q));
          q_ff[p] <= 16'(per_q);
        end
      end else begin
        word_ff[cmd_phase_i[1:0]] <= cmd_wdata_i;
        q_ff[cmd_phase_i[1:0]] <= 16'(wr_q);
      end
    end
  end

  // Effective stack offset and per-phase telemetry values.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      offset_sum_o <= 18'h00000;
      phase_offsets_o <= 64'h0;
    end else begin
      offset_sum_o <= 18'(q_ff[0]) + ((n_phase_ff > 3'h1) ? 18'(q_ff[1]) : 18'h0) +
                      ((n_phase_ff > 3'h2) ? 18'(q_ff[2]) : 18'h0) +
                      ((n_phase_ff > 3'h3) ? 18'(q_ff[3]) : 18'h0);
      phase_offsets_o <= {q_ff[3], q_ff[2], q_ff[1], q_ff[0]};
    end
  end

  // ---------------------------------------------------------------
  // Overvoltage limit storage and detection
  // ---------------------------------------------------------------
  // Stored limit word; a voltage command change never rewrites it.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ov_word_ff <= OV_WORD_RST;
    end else if (nvm_restore_i) begin
      ov_word_ff <= nvm_ov_word_i;
    end else if (cmd_valid_i && cmd_write_i && sel_ov && wr_map[11]) begin
      ov_word_ff <= cmd_wdata_i;
    end
  end

  // Effective percentage and comparator against the sensed output.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ov_pct_o <= OV_PCT_MAX;
      ov_fault_o <= 1'b0;
      ov_event_o <= 1'b0;
    end else begin
      ov_pct_o <= cur_map[10:0];
      ov_fault_o <= por_done_ff &&
                    sense_lhs > 64'(vout_command_i) * 64'(ov_pct_o);
      ov_event_o <= por_done_ff && !ov_fault_o &&
                    sense_lhs > 64'(vout_command_i) * 64'(ov_pct_o);
    end
  end

  // ---------------------------------------------------------------
  // Host answers
  // ---------------------------------------------------------------
  // One-cycle answer with read data and invalid-data flag.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 16'h0000;
      rsp_invalid_o <= 1'b0;
    end else begin
      rsp_valid_o <= cmd_valid_i;
      rsp_rdata_o <= 16'h0000;
      rsp_invalid_o <= 1'b0;
      if (cmd_valid_i && sel_offset) begin
        if (!phase_ok) rsp_invalid_o <= 1'b1;
        else if (cmd_write_i) rsp_invalid_o <= !wr_off_ok;
        else if (bcast) rsp_rdata_o <= encode_word(bcast_rd);
        else rsp_rdata_o <= word_ff[cmd_phase_i[1:0]];
      end else if (cmd_valid_i && sel_ov) begin
        if (cmd_write_i) rsp_invalid_o <= !wr_map[11];
        else rsp_rdata_o <= ov_word_ff;
      end else if (cmd_valid_i) begin
        rsp_invalid_o <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Fault response sequencer
  // ---------------------------------------------------------------
  // act on response
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= RESP_MONITOR;
      count_ff <= 28'h0;
      attempts_ff <= 3'h0;
      shutdown_o <= 1'b0;
      restart_o <= 1'b0;
    end else begin
      restart_o <= 1'b0;
      case (state_ff)
        RESP_MONITOR, RESP_SETTLE: begin
          if (ov_fault_o && resp_mode != RESP_IGNORE) begin
            shutdown_o <= 1'b1;
            if (resp_retry == 3'h0 ||
                (resp_retry != RETRY_FOREVER && attempts_ff >= resp_retry)) begin
              state_ff <= RESP_LATCHED;
            end else begin
              state_ff <= RESP_HICCUP;
              attempts_ff <= attempts_ff + 3'h1;
              count_ff <= 28'(ton_rise_cycles_i) *
                          ((resp_delay == 3'h0) ? 28'h1 : 28'(resp_delay));
            end
          end else if (state_ff == RESP_SETTLE) begin
            if (count_ff <= 28'h1) begin
              state_ff <= RESP_MONITOR;
              attempts_ff <= 3'h0;
            end else begin
              count_ff <= count_ff - 28'h1;
            end
          end
        end
        RESP_HICCUP: begin
          if (count_ff <= 28'h1) begin
            state_ff <= RESP_SETTLE;
            shutdown_o <= 1'b0;
            restart_o <= 1'b1;
            count_ff <= 28'(ton_rise_cycles_i) << 1;
          end else begin
            count_ff <= count_ff - 28'h1;
          end
        end
        RESP_LATCHED: begin
          // Only a commanded off releases a latched shutdown.
          if (!conv_enable_i) begin
            state_ff <= RESP_MONITOR;
            shutdown_o <= 1'b0;
            attempts_ff <= 3'h0;
          end
        end
        default: state_ff <= RESP_MONITOR;
      endcase
    end
  end
endmodule : iout_offset_ov_limit
`default_nettype wire

//--- src/trim_limit_pkg.sv
// Constants for the current-sense offset trim and overvoltage limit commands.
package trim_limit_pkg;
  // ---------------------------------------------------------------
  // Command codes and phase selection
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_OFFSET_TRIM = 8'h39;
  localparam logic [7:0] CMD_OV_THRESHOLD = 8'h40;
  localparam logic [7:0] PHASE_BCAST = 8'hff;
  localparam logic [7:0] PHASE_LAST = 8'h03;
  localparam int MAX_PHASES = 4;
  // ---------------------------------------------------------------
  // Offset word layout and fixed-point form (LSB = 2^-10 A)
  // ---------------------------------------------------------------
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MAN_MSB = 10;
  localparam logic [4:0] OFFSET_EXP_RST = 5'b11100;
  localparam int Q_FRAC = 10;
  localparam int NVM_GRID_SHIFT = 6;
  localparam logic signed [47:0] OFFSET_MIN_Q = -48'sd8192;
  localparam logic signed [47:0] OFFSET_MAX_Q = 48'sd8128;
  localparam int ENC_MAX_SHIFT = 5;
  // ---------------------------------------------------------------
  // Overvoltage thresholds in tenths of a percent
  // ---------------------------------------------------------------
  localparam logic [15:0] OV_WORD_RST = 16'hffff;
  localparam int PCT_SCALE = 1000;
  localparam int OV_PCT_MIN = 1050;
  localparam int OV_PCT_STEP = 25;
  localparam int OV_PCT_STEPS = 15;
  localparam int OV_OFF_MIN = 1100;
  localparam int OV_OFF_STEP = 100;
  localparam logic [10:0] OV_PCT_MAX = 11'd1400;
  // ---------------------------------------------------------------
  // Fault response byte layout and codes
  // ---------------------------------------------------------------
  localparam int RESP_MODE_LSB = 6;
  localparam int RESP_RETRY_LSB = 3;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [2:0] PHASES_RST = 3'h1;
  typedef enum {RESP_MONITOR, RESP_HICCUP, RESP_SETTLE, RESP_LATCHED} resp_state_t;
endpackage : trim_limit_pkg
